/* File: core/fmon_freq_monitor.sv */
// main-clock frequency monitor: sub-clock window, divided-clock capture, verdict
//
// Overview of operation
// - The measurement window is timed by the sub-clock, a reference independent of mclk.
// - One window lasts 512 sub-clock periods, about 15.6 ms.
// - A captured count from 42187 to 51562 inclusive is normal, anything else abnormal.
// - One start request yields one measurement whose verdict is kept, never repeated alone.
// - The period timer counts up by one on each rising edge of the sub-clock input.
// - The period timer compares against 512 minus one, so it matches once per window.
// - The period timer returns to zero when its count equals the compare value.
// - The period timer drives nothing on its pin and raises no interrupt.
// - The capture timer counts up on mclk divided by 16.
// - A period-timer match copies the capture timer's count into the capture register.
// - The capture timer clears to zero on each capture.
// - Each capture raises the capture A interrupt request.
// - At the end the verdict goes to the error flag first, then the completion flag is set.
// - The first capture is discarded, the second is judged, and both timers then stop.
// - Error reads 0 normal, 1 abnormal; completion reads 0 until the measurement ends.
`timescale 1ns/1ps
module fmon_freq_monitor
  import fmon_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // reference pin
  input wire logic external_count_input,
  // software control
  input wire logic start_req,
  // results
  output fmon_status_s status,
  output logic [15:0] general_compare_capture_reg_a,
  output logic capture_a_interrupt_request,
  // period timer pin, never driven
  output logic period_timer_io_pin_out,
  output logic period_timer_io_pin_oe_n
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ----------------------------------------------------------------
  // reference edges
  // ----------------------------------------------------------------
  logic ref_rise;

  fmon_sync_edge u_ref_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(external_count_input),
    .rise(ref_rise)
  );

  // ----------------------------------------------------------------
  // shared terms
  // ----------------------------------------------------------------
  fmon_state_e state;
  fmon_state_e next_state;
  fmon_timers_s tm;
  fmon_timers_s next_tm;
  logic [15:0] next_cap;
  logic next_irq;
  logic start_q;
  logic next_start_q;
  fmon_status_s next_status;
  logic next_pin_out;
  logic next_pin_oe_n;
  logic start_pulse;
  logic start_go;
  logic running;
  logic tick;
  logic match;

  // a held start flag must not restart a finished measurement
  assign start_pulse = start_req & ~start_q;
  assign start_go = start_pulse && (state == ST_IDLE);
  assign running = (state == ST_FIRST) || (state == ST_SECOND);
  assign tick = running && (tm.presc == PRESC_LAST);
  assign match = running && ref_rise && (tm.win_cnt == PT_CMP);

  // ----------------------------------------------------------------
  // timers and capture
  // ----------------------------------------------------------------
  always_comb begin
    next_tm = tm;
    next_cap = general_compare_capture_reg_a;
    next_irq = 1'b0;
    if (start_go) begin
      next_tm = '0;
    end else if (running) begin
      next_tm.presc = tm.presc + PRESC_STEP;
      if (tick) begin
        next_tm.cap_cnt = tm.cap_cnt + CAP_STEP;
      end
      if (ref_rise) begin
        if (tm.win_cnt == PT_CMP) begin
          next_tm.win_cnt = '0;
        end else begin
          next_tm.win_cnt = tm.win_cnt + PT_STEP;
        end
      end
      if (match) begin
        next_cap = tm.cap_cnt;
        next_tm.cap_cnt = '0;
        next_irq = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tm <= '0;
      general_compare_capture_reg_a <= '0;
      capture_a_interrupt_request <= 1'b0;
    end else if (ce) begin
      tm <= next_tm;
      general_compare_capture_reg_a <= next_cap;
      capture_a_interrupt_request <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // sequence and flags
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_status = status;
    next_start_q = start_req;
    next_pin_out = 1'b0;
    next_pin_oe_n = 1'b1;
    case (state)
      ST_IDLE: begin
        if (start_go) begin
          next_state = ST_FIRST;
          next_status.done = 1'b0;
          next_status.err = 1'b0;
        end
      end
      ST_FIRST: begin
        if (match) begin
          next_state = ST_SECOND;
        end
      end
      ST_SECOND: begin
        if (match) begin
          next_state = ST_VERDICT;
        end
      end
      ST_VERDICT: begin
        next_status.err = !fmon_in_range(general_compare_capture_reg_a);
        next_state = ST_COMPLETE;
      end
      ST_COMPLETE: begin
        next_status.done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_status.busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      status <= '0;
      start_q <= 1'b0;
      period_timer_io_pin_out <= 1'b0;
      period_timer_io_pin_oe_n <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      status <= next_status;
      start_q <= next_start_q;
      period_timer_io_pin_out <= next_pin_out;
      period_timer_io_pin_oe_n <= next_pin_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_window_step: assert property (
    ce && running && ref_rise && (tm.win_cnt != PT_CMP) && !match
      |=> tm.win_cnt == $past(tm.win_cnt) + PT_STEP)
    else $error("period timer did not step on a reference edge");

  a_window_wrap: assert property (
    ce && match |=> (tm.win_cnt == '0))
    else $error("period timer did not return to zero on match");

  a_match_at_cmp: assert property (
    match |-> (tm.win_cnt == PT_CMP) && ref_rise)
    else $error("match away from the compare value");

  a_capture_copy: assert property (
    ce && match |=> general_compare_capture_reg_a == $past(tm.cap_cnt))
    else $error("capture register missed the count");

  a_capture_clear: assert property (
    ce && match |=> (tm.cap_cnt == '0))
    else $error("capture timer not cleared on capture");

  a_irq_capture: assert property (
    capture_a_interrupt_request && $past(ce) |-> $past(match))
    else $error("interrupt request without capture");

  a_irq_follows: assert property (
    ce && match |=> capture_a_interrupt_request)
    else $error("capture raised no interrupt request");

  a_presc_hold: assert property (
    ce && running && !match && !tick |=> $stable(tm.cap_cnt))
    else $error("capture timer moved between divided ticks");

  a_verdict_range: assert property (
    ce && (state == ST_VERDICT)
      |=> status.err == !fmon_in_range($past(general_compare_capture_reg_a)))
    else $error("verdict disagrees with the limits");

  a_err_before_done: assert property (
    ce && (state == ST_VERDICT) |=> !status.done ##1 (status.done || !ce))
    else $error("completion did not follow the verdict");

  a_first_discard: assert property (
    ce && (state == ST_FIRST) && match |=> (state == ST_SECOND) && !status.done)
    else $error("first capture was not discarded");

  a_timers_stop: assert property (
    ce && (state == ST_IDLE) && !start_pulse |=> (state == ST_IDLE) && $stable(tm))
    else $error("timers ran without a start request");

  a_done_low_busy: assert property (
    running |-> !status.done)
    else $error("completion set during measurement");

  a_pin_quiet: assert property (
    period_timer_io_pin_oe_n && !period_timer_io_pin_out)
    else $error("period timer pin driven");

  c_first_capture: cover property (ce && (state == ST_FIRST) && match);
  c_second_capture: cover property (ce && (state == ST_SECOND) && match);
  c_abnormal: cover property ($rose(status.done) && status.err);
  c_normal: cover property ($rose(status.done) && !status.err);

endmodule

/* File: core/fmon_pkg.sv */
// constants, types and helpers shared by the main-clock frequency monitor
package fmon_pkg;

  // ----------------------------------------------------------------
  // measurement window and count clock
  // ----------------------------------------------------------------
  localparam int unsigned REF_DIV = 512;
  localparam logic [8:0] PT_CMP = 9'(REF_DIV - 1);
  localparam logic [8:0] PT_STEP = 9'h001;
  localparam logic [3:0] PRESC_LAST = 4'hF;
  localparam logic [3:0] PRESC_STEP = 4'h1;
  localparam logic [15:0] CAP_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // judgement limits, inclusive
  // ----------------------------------------------------------------
  localparam logic [15:0] FREQ_MIN = 16'hA4CB;
  localparam logic [15:0] FREQ_MAX = 16'hC96A;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND,
    ST_VERDICT,
    ST_COMPLETE
  } fmon_state_e;

  typedef struct packed {
    logic [8:0] win_cnt;
    logic [3:0] presc;
    logic [15:0] cap_cnt;
  } fmon_timers_s;

  typedef struct packed {
    logic busy;
    logic err;
    logic done;
  } fmon_status_s;

  function automatic logic fmon_in_range(input logic [15:0] v);
    return (v >= FREQ_MIN) && (v <= FREQ_MAX);
  endfunction

endpackage

/* File: core/fmon_sync_edge.sv */
// two-stage synchroniser with rising-edge detect for an asynchronous pin
`timescale 1ns/1ps
module fmon_sync_edge (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // asynchronous level in, synchronous edge out
  input wire logic async_in,
  output logic rise
);

  logic meta;
  logic sync;
  logic sync_q;
  logic next_meta;
  logic next_sync;
  logic next_sync_q;

  always_comb begin
    next_meta = async_in;
    next_sync = meta;
    next_sync_q = sync;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      sync_q <= 1'b0;
    end else if (ce) begin
      meta <= next_meta;
      sync <= next_sync;
      sync_q <= next_sync_q;
    end
  end

  // the first stage is read only by the second
  assign rise = sync & ~sync_q;

endmodule

/* File: test/fmon_freq_monitor_tb.sv */
// self-checking bench for the main-clock frequency monitor
`timescale 1ns/1ps
module fmon_freq_monitor_tb;
  import fmon_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic start_req = 1'b0;
  logic ref_en = 1'b0;
  logic [15:0] half_ns = 16'h0096;
  logic ref_clk;
  fmon_status_s status;
  logic [15:0] cap;
  logic irq;
  logic pin_out;
  logic pin_oe_n;
  int seed = 42689;
  int fails = 0;
  int comparisons = 0;
  int irqs = 0;

  initial forever #25 mclk = ~mclk;

  fmon_sub_clock_model u_fmon_sub_clock_model (.enable(ref_en), .half_ns(half_ns),
    .ref_clk(ref_clk));
  fmon_freq_monitor u_fmon_freq_monitor (.mclk(mclk), .nrst(nrst), .ce(ce),
    .external_count_input(ref_clk), .start_req(start_req), .status(status),
    .general_compare_capture_reg_a(cap), .capture_a_interrupt_request(irq),
    .period_timer_io_pin_out(pin_out), .period_timer_io_pin_oe_n(pin_oe_n));

  always @(posedge mclk) begin
    if (irq === 1'b1) begin
      irqs <= irqs + 1;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one measurement against the integer model
  // ----------------------------------------------------------------
  // a normal count needs ~675k cycles per window, so only fast references fit the run
  task automatic measure(input int n);
    int h;
    int exp_cnt;
    int k;
    int irq0;
    logic exp_err;
    logic err_prev;
    h = 100 + ($unsigned($random(seed)) % 100);
    exp_cnt = (1024 * h) / 800;
    exp_err = (exp_cnt < int'(FREQ_MIN)) || (exp_cnt > int'(FREQ_MAX));
    half_ns <= 16'(h);
    irq0 = irqs;
    err_prev = 1'b0;
    @(posedge mclk);
    start_req <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check("busy", 16'(status.busy), 16'h0001);
    check("done_low", 16'(status.done), 16'h0000);
    check("err_clear", 16'(status.err), 16'h0000);
    @(posedge mclk);
    start_req <= 1'b0;
    repeat (3) @(posedge mclk);
    start_req <= 1'b1;
    for (k = 0; k < 20000; k++) begin
      @(posedge mclk);
      #1;
      if (status.done === 1'b1) begin
        break;
      end
      err_prev = status.err;
    end
    if (k == 20000) begin
      fails++;
      test_done();
    end
    check("err_before_done", 16'(err_prev), 16'(exp_err));
    check("err", 16'(status.err), 16'(exp_err));
    check("busy_end", 16'(status.busy), 16'h0000);
    check("irq_count", 16'(irqs - irq0), 16'h0002);
    check("cap_near", 16'((int'(cap) >= exp_cnt - 2) && (int'(cap) <= exp_cnt + 2)),
      16'h0001);
    repeat (300) @(posedge mclk);
    #1;
    check("held_start", 16'({status.busy, status.done}), 16'h0001);
    check("irq_quiet", 16'(irqs - irq0), 16'h0002);
    check("pin", 16'({pin_out, pin_oe_n}), 16'h0001);
    @(posedge mclk);
    start_req <= 1'b0;
    $display("test measure %0d done, half period %0d ns", n, h);
  endtask

  initial begin
    repeat (15) @(posedge mclk);
    #1;
    check("rst_status", 16'(status), 16'h0000);
    check("rst_cap", cap, 16'h0000);
    check("rst_pin", 16'({irq, pin_out, pin_oe_n}), 16'h0001);
    @(posedge mclk);
    nrst <= 1'b1;
    ref_en <= 1'b1;
    repeat (2000) @(posedge mclk);
    #1;
    check("idle_irq", 16'(irqs), 16'h0000);
    check("idle_cap", cap, 16'h0000);
    $display("test idle done");
    for (int i = 0; i < 3; i++) begin
      measure(i);
    end
    @(posedge mclk);
    start_req <= 1'b1;
    repeat (1500) @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check("mid_rst_status", 16'(status), 16'h0000);
    check("mid_rst_cap", cap, 16'h0000);
    @(posedge mclk);
    nrst <= 1'b1;
    start_req <= 1'b0;
    repeat (4) @(posedge mclk);
    $display("test mid reset done");
    measure(3);
    test_done();
  end
endmodule

/* File: test/fmon_sub_clock_model.sv */
// free-running sub-clock oscillator standing in for the external reference
`timescale 1ns/1ps
module fmon_sub_clock_model (
  // control
  input wire logic enable,
  input wire logic [15:0] half_ns,
  // reference pin
  output logic ref_clk
);
  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  // odd start offset and a half period in ns, so edges drift against mclk
  initial begin
    ref_clk = 1'b0;
    #7;
    forever begin
      #(half_ns);
      if (enable) begin
        ref_clk = ~ref_clk;
      end
    end
  end
endmodule
